// file: bench/sps_peer.sv
// Behavioural serial peer on the far side of the port, in either role.
// Assumes the bench sets its clock mode to match the port's configuration.
`timescale 1ns/100ps
`default_nettype none
module sps_peer (
	input wire logic sck,
	input wire logic sdo,
	input wire logic pol,
	input wire logic edge_sel,
	input wire logic load,
	input wire logic [15:0] load_word,
	output logic sdi,
	output logic [15:0] got
);
	logic [15:0] sr;
	logic hold;
	initial
	begin
		sr = 16'h0000;
		hold = 1'b0;
		got = 16'h0000;
	end
	always @(posedge load)
		sr <= load_word;
	// change on one edge, sample on the other
	always @(sck)
	begin
		if ((sck ^ pol) != edge_sel)
		begin
			hold <= sr[15];
			sr <= {sr[14:0], 1'b0};
		end
		else
			got <= {got[14:0], sdo};
	end
	assign sdi = edge_sel ? sr[15] : hold;
endmodule
`default_nettype wire

// file: bench/sps_port_tb.sv
// Self-checking bench for the serial port, driven over AXI4-Lite.
// Assumes the peer answers on the link; the bench clocks a slave port.
`timescale 1ns/100ps
`default_nettype none
module sps_port_tb
	import sps_pkg::*;
;
	logic aclk, aresetn, idle_mode;
	logic [3:0] s_axi_awaddr, s_axi_araddr, s_axi_wstrb;
	logic [31:0] s_axi_wdata, s_axi_rdata, rdv;
	logic [1:0] s_axi_bresp, s_axi_rresp, rrs;
	logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
	logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
	logic s_axi_rvalid, s_axi_rready, serial_in_pin;
	logic shift_clock_pin_o, shift_clock_pin_oe, serial_out_pin_o;
	logic serial_out_pin_oe, select_pin_n_o, select_pin_n_oe;
	logic pol, edg, ld, bsck, fs_seen;
	logic [15:0] peer_word, got;
	int bad_count, check_count;
	wire sck_w = shift_clock_pin_oe ? shift_clock_pin_o : pol ^ bsck;
	wire sdo_w = serial_out_pin_oe ? serial_out_pin_o : 1'b1;
	wire ss_w = select_pin_n_oe ? select_pin_n_o : 1'b1;

	sps_port sps_port_i (
		.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
		.s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
		.s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
		.s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
		.s_axi_rvalid, .s_axi_rready, .idle_mode, .serial_in_pin,
		.shift_clock_pin_i(sck_w), .shift_clock_pin_o,
		.shift_clock_pin_oe, .serial_out_pin_o, .serial_out_pin_oe,
		.select_pin_n_i(ss_w), .select_pin_n_o, .select_pin_n_oe
	);
	sps_peer sps_peer_i (
		.sck(sck_w), .sdo(sdo_w), .pol(pol), .edge_sel(edg), .load(ld),
		.load_word(peer_word), .sdi(serial_in_pin), .got(got)
	);

	always #12.5 aclk = ~aclk;

	// Active-high sync pulse seen on the driven select pin
	always @(posedge aclk)
	begin
		if (!aresetn)
			fs_seen <= 1'b0;
		else if (select_pin_n_oe && select_pin_n_o)
			fs_seen <= 1'b1;
	end

	task automatic chk(input logic [31:0] s, input logic [31:0] e);
		check_count++;
		if (s !== e)
		begin
			bad_count++;
			$display("MISMATCH t=%0t seen=%h exp=%h", $time, s, e);
		end
	endtask
	task automatic wr(input logic [3:0] a, input logic [15:0] d);
		s_axi_awaddr <= a;
		s_axi_wdata <= {16'h0000, d};
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		forever
		begin
			@(posedge aclk);
			if (s_axi_awvalid && s_axi_awready)
				s_axi_awvalid <= 1'b0;
			if (s_axi_wvalid && s_axi_wready)
				s_axi_wvalid <= 1'b0;
			if (s_axi_bvalid)
				break;
		end
		chk({30'h0, s_axi_bresp}, {30'h0, RESP_OK});
	endtask
	task automatic rd(input logic [3:0] a);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		forever
		begin
			@(posedge aclk);
			if (s_axi_arvalid && s_axi_arready)
				s_axi_arvalid <= 1'b0;
			if (s_axi_rvalid)
				break;
		end
		rdv = s_axi_rdata;
		rrs = s_axi_rresp;
	endtask
	task automatic rc(input logic [3:0] a, input logic [31:0] e);
		rd(a);
		chk(rdv, e);
	endtask
	// Load the peer, then hand the port a word to send
	task automatic xfer(input logic [15:0] tx, input logic [15:0] pw);
		peer_word <= pw;
		ld <= 1'b1;
		@(posedge aclk);
		ld <= 1'b0;
		wr(OFS_BUF, tx);
	endtask
	task automatic wait_rbf();
		do
			rd(OFS_STAT);
		while (rdv[STAT_RBF] !== 1'b1);
	endtask
	task automatic end_sim();
		if (bad_count == 0 && check_count > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask

	initial
	begin
		aclk = 1'b0;
		aresetn = 1'b0;
		idle_mode = 1'b0;
		s_axi_awaddr = 4'h0;
		s_axi_araddr = 4'h0;
		s_axi_wstrb = 4'hf;
		s_axi_wdata = 32'h0;
		s_axi_awvalid = 1'b0;
		s_axi_wvalid = 1'b0;
		s_axi_arvalid = 1'b0;
		s_axi_bready = 1'b1;
		s_axi_rready = 1'b1;
		pol = 1'b0;
		edg = 1'b0;
		ld = 1'b0;
		bsck = 1'b0;
		peer_word = 16'h0000;
		bad_count = 0;
		check_count = 0;
		repeat (3) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		rc(OFS_STAT, 32'h0);
		rc(OFS_CFG1, 32'h0);
		rc(OFS_CFG2, 32'h0);
		rd(4'h2);
		chk({30'h0, rrs}, {30'h0, RESP_SLVERR});
		wr(OFS_CFG2, 16'hffff);
		rc(OFS_CFG2, {16'h0, CFG2_WMASK});
		wr(OFS_CFG2, 16'h0000);
		// master role, prescalers not both one-to-one
		wr(OFS_CFG1, 16'hfffe);
		rc(OFS_CFG1, {16'h0, CFG1_WMASK & 16'hfffe});
		// Word transfer at a 200 ns link clock
		wr(OFS_CFG1, 16'h043e);
		wr(OFS_STAT, 16'h8000);
		chk(shift_clock_pin_oe, 1'b1);
		xfer(16'hc3a1, 16'h5a96);
		wait_rbf();
		chk(rdv, 32'h8001);
		chk(got, 16'hc3a1);
		// Second word lands on an unread buffer
		xfer(16'h0f0f, 16'h1234);
		repeat (200) @(posedge aclk);
		rc(OFS_STAT, 32'h8041);
		rc(OFS_BUF, 32'h5a96);
		chk(got, 16'h0f0f);
		rc(OFS_STAT, 32'h8040);
		wr(OFS_STAT, 16'h8000);
		rc(OFS_STAT, 32'h8000);
		// Every clock mode, byte wide
		for (int i = 0; i < 4; i++)
		begin
			pol <= i[0];
			edg <= i[1];
			wr(OFS_CFG1, {7'h00, i[1], 1'b0, i[0], 6'h3e});
			xfer({8'h00, 8'h96 ^ 8'(i)}, {8'h69 + 8'(i), 8'h00});
			wait_rbf();
			rd(OFS_BUF);
			chk(rdv[7:0], 8'h69 + 8'(i));
			chk(got[7:0], 8'h96 ^ 8'(i));
			chk(shift_clock_pin_o, i[0]);
		end
		pol <= 1'b0;
		edg <= 1'b0;
		wr(OFS_CFG1, 16'h183e);
		chk(shift_clock_pin_oe, 1'b0);
		chk(serial_out_pin_oe, 1'b0);
		wr(OFS_CFG1, 16'h003e);
		chk(serial_out_pin_oe, 1'b1);
		// Frame sync pin driven by the port
		wr(OFS_CFG2, 16'ha000);
		repeat (2) @(posedge aclk);
		chk(select_pin_n_oe, 1'b1);
		chk(select_pin_n_o, 1'b0);
		// framed byte with edge bit clear, peer changes on trail
		edg <= 1'b1;
		xfer(16'h00c5, 16'h5300);
		wait_rbf();
		rd(OFS_BUF);
		chk(rdv[7:0], 8'h53);
		chk(got[7:0], 8'hc5);
		chk(fs_seen, 1'b1);
		edg <= 1'b0;
		wr(OFS_CFG2, 16'h8000);
		repeat (2) @(posedge aclk);
		chk(select_pin_n_o, 1'b1);
		wr(OFS_CFG2, 16'he000);
		chk(select_pin_n_oe, 1'b0);
		wr(OFS_CFG2, 16'h0000);
		// Halted while idle, resumes after
		wr(OFS_STAT, 16'ha000);
		idle_mode <= 1'b1;
		xfer(16'h00a5, 16'h3c00);
		repeat (200) @(posedge aclk);
		rd(OFS_STAT);
		chk(rdv[STAT_RBF], 1'b0);
		idle_mode <= 1'b0;
		wait_rbf();
		rd(OFS_BUF);
		chk(rdv[7:0], 8'h3c);
		wr(OFS_STAT, 16'h0000);
		chk(shift_clock_pin_oe, 1'b0);
		chk(serial_out_pin_oe, 1'b0);
		// slave word, sample phase clear, bench clocks the link
		wr(OFS_CFG1, 16'h0400);
		xfer(16'h6b2d, 16'h9e47);
		wr(OFS_STAT, 16'h8000);
		repeat (16)
		begin
			repeat (4) @(posedge aclk);
			bsck <= 1'b1;
			repeat (4) @(posedge aclk);
			bsck <= 1'b0;
		end
		repeat (8) @(posedge aclk);
		rc(OFS_BUF, 32'h9e47);
		chk(got, 16'h6b2d);
		chk(shift_clock_pin_oe, 1'b0);
		end_sim();
	end

	initial
	begin
		#(25 * 30000);
		bad_count++;
		end_sim();
	end
endmodule
`default_nettype wire

// file: rtl/sps_pkg.sv
// Package for the framed serial port: register map, fields, resets, states.
// Assumes a 32-bit AXI4-Lite register bus, registers one per aligned word.
package sps_pkg;
	localparam logic [3:0] OFS_STAT = 4'h0;
	localparam logic [3:0] OFS_CFG1 = 4'h4;
	localparam logic [3:0] OFS_CFG2 = 4'h8;
	localparam logic [3:0] OFS_BUF = 4'hc;
	localparam logic [3:0] OFS_CTRL = 4'h0;
	// Status register fields
	localparam int STAT_EN = 15;
	localparam int STAT_SIDL = 13;
	localparam int STAT_ROV = 6;
	localparam int STAT_TBF = 1;
	localparam int STAT_RBF = 0;
	// Configuration one fields
	localparam int C1_CLOCK_PIN_DISABLE = 12;
	localparam int C1_DATA_OUT_DISABLE = 11;
	localparam int C1_WIDE = 10;
	localparam int C1_SMP = 9;
	localparam int C1_EDGE = 8;
	localparam int C1_SELECT_ENABLE = 7;
	localparam int C1_POL = 6;
	localparam int C1_MST = 5;
	localparam int C1_SPRE = 2;
	localparam int C1_PPRE = 0;
	// Configuration two fields
	localparam int C2_FRM = 15;
	localparam int C2_FSD = 14;
	localparam int C2_FPOL = 13;
	localparam int C2_FDLY = 1;
	localparam logic [15:0] CFG1_WMASK = 16'h1fff;
	localparam logic [15:0] CFG2_WMASK = 16'he002;
	localparam logic [15:0] RST_REG = 16'h0000;
	localparam int SR_W = 16;
	localparam logic [1:0] RESP_OK = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	typedef struct packed {
		logic sck;
		logic sdo;
		logic ss;
	} sps_pin_t;
	typedef enum logic [3:0] {
		ST_IDLE = 4'b0001,
		ST_SYNC = 4'b0010,
		ST_SHIFT = 4'b0100,
		ST_DONE = 4'b1000
	} sps_state_t;
endpackage

// file: rtl/sps_port.sv
// Framed serial port: master or slave, AXI4-Lite register slave.
// Assumes pin inputs are asynchronous; idle_mode comes from on-clock logic.
// Notes on behaviour
// R1: Data shifts through a 16-bit register with separate transmit and receive buffers.
// R2: Four pins; clock driven as master, received as slave.
// R3: Enable bit 15 of status hands pins to the module, clear disables.
// R4: Idle-stop bit 13 halts the module while device is idle; a slave shift already under way keeps running on the pin clock.
// R5: Word arriving with receive buffer unread is discarded, overflow bit 6 set.
// R6: Transmit-full bit 1 set on buffer write, cleared on move to shifter.
// R7: Receive-full bit 0 set on move to receive buffer, cleared on read.
// R8: Master clock-pin disable bit 12 stops driving the clock pin.
// R9: Data-out disable bit 11 releases the serial output pin.
// R10: Width bit 10 selects 16-bit transfers when set, 8-bit when clear.
// R11: Master samples input at end of bit when bit 9 set, else middle.
// R12: Software keeps sample-phase bit clear in slave mode.
// R13: Edge bit 8 set: data changes active-to-idle; clear: idle-to-active.
// R14: Edge bit is ignored in framed mode; software programs it zero.
// R15: Slave uses select pin when bit 7 set; cleared in framed mode.
// R16: Polarity bit 6 set gives high idle clock, clear low idle.
// R17: Role bit 5 set selects master, clear selects slave.
// R18: Software never sets both prescalers to one-to-one.
// R19: Framed bit 15 of config two turns select pin into frame sync.
// R20: Sync direction bit 14 set takes sync as input, clear drives it.
// R21: Sync polarity bit 13 set gives active-high sync, clear active-low.
// R22: Sync edge bit 1 set aligns sync with first bit, else one before.
// R23: Master clock divides system clock by primary then secondary prescale.
// R24: Most significant bit first, one bit out and one in per clock.
//
// The implementer's own choices: the AXI4-Lite interface to the registers and the register addresses.
`timescale 1ns/100ps
`default_nettype none
module sps_port
	import sps_pkg::*;
(
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [3:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [3:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic idle_mode,
	input wire logic serial_in_pin,
	input wire logic shift_clock_pin_i,
	output logic shift_clock_pin_o,
	output logic shift_clock_pin_oe,
	output logic serial_out_pin_o,
	output logic serial_out_pin_oe,
	input wire logic select_pin_n_i,
	output logic select_pin_n_o,
	output logic select_pin_n_oe
);
	// Registers and bus state
	logic [15:0] stat_ff, cfg1_ff, cfg2_ff, txb_ff, rxb_ff, sr_ff;
	logic [15:0] nxt_stat, nxt_cfg1, nxt_cfg2, nxt_txb, nxt_rxb, nxt_sr;
	logic aw_ff, w_ff, bv_ff, rv_ff, nxt_aw, nxt_w, nxt_bv, nxt_rv;
	logic [3:0] awa_ff, nxt_awa;
	logic [15:0] wd_ff, nxt_wd;
	logic [31:0] rd_ff, nxt_rd;
	logic [1:0] br_ff, rr_ff, nxt_br, nxt_rr;
	// Link state
	sps_state_t st_ff, nxt_st;
	logic [4:0] cnt_ff, nxt_cnt;
	logic [8:0] div_ff, nxt_div;
	logic half_ff, nxt_half;
	logic sck_ff, nxt_sck, sdo_ff, nxt_sdo, fs_ff, nxt_fs;
	logic [2:0] sck_s, sdi_s, ss_s;
	sps_pin_t pin;
	logic en, run, mst, frm, wide, lead_ed, trail_ed, s_lead, s_trail;
	logic [4:0] nbits;
	logic [8:0] div_top;
	logic tick, wr_go, rd_buf, load, done, ss_act, smp_trail;

	assign en = stat_ff[STAT_EN];
	// R4: idle stop
	assign run = en && !(stat_ff[STAT_SIDL] && idle_mode);
	// R17: role select
	assign mst = cfg1_ff[C1_MST];
	assign frm = cfg2_ff[C2_FRM];
	// R10: transfer width
	assign wide = cfg1_ff[C1_WIDE];
	assign nbits = wide ? 5'd16 : 5'd8;
	// R23: two-stage prescale, primary x secondary
	// Nine bits: the slowest setting needs a count of 511
	assign div_top = 9'((5'd1 << (2 * (3 - cfg1_ff[1:0]))) *
		(4'd8 - {1'b0, cfg1_ff[4:2]}) - 1);

	// Pin synchronisers; stage 0 feeds only stage 1
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			sck_s <= 3'h0;
			sdi_s <= 3'h0;
			ss_s <= 3'h7;
		end
		else
		begin
			sck_s <= {sck_s[1:0], shift_clock_pin_i};
			sdi_s <= {sdi_s[1:0], serial_in_pin};
			ss_s <= {ss_s[1:0], select_pin_n_i};
		end
	end
	// R16: slave edges relative to idle level
	assign s_lead = (sck_s[1] ^ cfg1_ff[C1_POL]) &&
		!(sck_s[2] ^ cfg1_ff[C1_POL]);
	assign s_trail = !(sck_s[1] ^ cfg1_ff[C1_POL]) &&
		(sck_s[2] ^ cfg1_ff[C1_POL]);
	// R15: select pin gates slave; R21: sync polarity
	assign ss_act = frm ? (ss_s[1] == cfg2_ff[C2_FPOL])
		: (!cfg1_ff[C1_SELECT_ENABLE] || !ss_s[1]);
	assign tick = run && mst && div_ff == div_top;
	// R2: master makes the clock, slave takes it from the pin
	// Master: leading edge is first half, trailing edge second
	assign lead_ed = mst ? (tick && !half_ff) : (s_lead && ss_act);
	assign trail_ed = mst ? (tick && half_ff) : (s_trail && ss_act);
	// R11: middle sample sits opposite the data change edge
	// End-of-bit sample uses the trailing edge in every clock mode
	assign smp_trail = (mst && cfg1_ff[C1_SMP]) ||
		!(cfg1_ff[C1_EDGE] || frm);

	assign wr_go = aw_ff && w_ff && !bv_ff;
	assign rd_buf = s_axi_arvalid && s_axi_arready && s_axi_araddr == OFS_BUF;
	// R6: transmit buffer into shifter
	assign load = run && st_ff == ST_IDLE && stat_ff[STAT_TBF] &&
		(mst || !frm || !cfg2_ff[C2_FSD] || ss_act);
	assign done = st_ff == ST_DONE;

	always_comb
	begin
		nxt_st = st_ff;
		nxt_cnt = cnt_ff;
		nxt_sr = sr_ff;
		nxt_div = tick ? 9'h000 : (run && mst ? div_ff + 9'h001 : 9'h000);
		nxt_half = half_ff;
		nxt_sck = sck_ff;
		nxt_sdo = sdo_ff;
		nxt_fs = 1'b0;
		if (!run)
		begin
			nxt_half = 1'b0;
			nxt_sck = 1'b0;
		end
		else if (tick)
			nxt_half = !half_ff;
		case (st_ff)
			ST_IDLE:
			begin
				nxt_half = 1'b0;
				nxt_sck = 1'b0;
				if (load || (!mst && run && !frm))
				begin
					// R1: shifter loaded, slave arms with stale data
					// R24: MSB first
					nxt_sr = load ? txb_ff : sr_ff;
					nxt_sdo = wide ? nxt_sr[15] : nxt_sr[7];
					nxt_cnt = 5'd0;
					// R19: framed mode begins with sync
					// R22: sync one clock early unless aligned
					nxt_st = (frm && !cfg2_ff[C2_FDLY]) ? ST_SYNC : ST_SHIFT;
					nxt_fs = frm && cfg2_ff[C2_FDLY];
					if (!load && !ss_act)
						nxt_st = ST_IDLE;
				end
			end
			ST_SYNC:
			begin
				nxt_fs = 1'b1;
				if (trail_ed)
				begin
					nxt_fs = 1'b0;
					nxt_st = ST_SHIFT;
				end
			end
			ST_SHIFT:
			begin
				if (lead_ed)
				begin
					nxt_sck = 1'b1;
					// R11: sample on the leading edge
					if (!smp_trail)
						nxt_sr = {sr_ff[14:0], sdi_s[1]};
					// R13: change on idle-to-active, unless framed
					if (cfg1_ff[C1_EDGE] == 1'b0 && cnt_ff != 5'd0 && !frm)
						nxt_sdo = wide ? sr_ff[15] : sr_ff[7];
				end
				if (trail_ed)
				begin
					nxt_sck = 1'b0;
					// R11: sample on the trailing edge
					if (smp_trail)
						nxt_sr = {sr_ff[14:0], sdi_s[1]};
					// R24: next bit out
					// R14: framed mode ignores the edge bit
					if (cfg1_ff[C1_EDGE] || frm)
						nxt_sdo = wide ? nxt_sr[15] : nxt_sr[7];
					nxt_cnt = cnt_ff + 5'd1;
					if (cnt_ff + 5'd1 == nbits)
						nxt_st = ST_DONE;
				end
				if (st_ff == ST_SHIFT && cnt_ff == 5'd0 && !lead_ed)
					nxt_fs = frm && cfg2_ff[C2_FDLY] && half_ff == 1'b0;
			end
			ST_DONE:
				nxt_st = ST_IDLE;
			default:
				nxt_st = ST_IDLE;
		endcase
		if (!en)
			nxt_st = ST_IDLE;
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			st_ff <= ST_IDLE;
			cnt_ff <= 5'd0;
			sr_ff <= RST_REG;
			div_ff <= 9'h000;
			half_ff <= 1'b0;
			sck_ff <= 1'b0;
			sdo_ff <= 1'b0;
			fs_ff <= 1'b0;
		end
		else
		begin
			st_ff <= nxt_st;
			cnt_ff <= nxt_cnt;
			sr_ff <= nxt_sr;
			div_ff <= nxt_div;
			half_ff <= nxt_half;
			sck_ff <= nxt_sck;
			sdo_ff <= nxt_sdo;
			fs_ff <= nxt_fs;
		end
	end

	// Pin drive
	assign pin.sck = sck_ff ^ cfg1_ff[C1_POL];
	assign pin.sdo = sdo_ff;
	assign pin.ss = fs_ff ~^ cfg2_ff[C2_FPOL];
	assign shift_clock_pin_o = pin.sck;
	// R3: pins belong to module only when enabled; R8: clock disable
	assign shift_clock_pin_oe = en && mst && !cfg1_ff[C1_CLOCK_PIN_DISABLE];
	assign serial_out_pin_o = pin.sdo;
	// R9: data out release
	assign serial_out_pin_oe = en && !cfg1_ff[C1_DATA_OUT_DISABLE];
	assign select_pin_n_o = pin.ss;
	// R20: sync driven only as sync master
	assign select_pin_n_oe = en && frm && !cfg2_ff[C2_FSD];

	// AXI4-Lite write and read
	assign s_axi_awready = !aw_ff && !bv_ff;
	assign s_axi_wready = !w_ff && !bv_ff;
	assign s_axi_bvalid = bv_ff;
	assign s_axi_bresp = br_ff;
	assign s_axi_arready = !rv_ff;
	assign s_axi_rvalid = rv_ff;
	assign s_axi_rdata = rd_ff;
	assign s_axi_rresp = rr_ff;

	always_comb
	begin
		nxt_aw = aw_ff;
		nxt_w = w_ff;
		nxt_awa = awa_ff;
		nxt_wd = wd_ff;
		nxt_bv = bv_ff && !s_axi_bready;
		nxt_br = br_ff;
		nxt_rv = rv_ff && !s_axi_rready;
		nxt_rd = rd_ff;
		nxt_rr = rr_ff;
		nxt_stat = stat_ff;
		nxt_cfg1 = cfg1_ff;
		nxt_cfg2 = cfg2_ff;
		nxt_txb = txb_ff;
		nxt_rxb = rxb_ff;
		if (s_axi_awvalid && s_axi_awready)
		begin
			nxt_aw = 1'b1;
			nxt_awa = s_axi_awaddr;
		end
		if (s_axi_wvalid && s_axi_wready)
		begin
			nxt_w = 1'b1;
			nxt_wd = s_axi_wstrb[1:0] == 2'b11 ? s_axi_wdata[15:0] : 16'h0;
		end
		// R6: shifter load empties transmit buffer
		if (load)
			nxt_stat[STAT_TBF] = 1'b0;
		if (wr_go)
		begin
			nxt_aw = 1'b0;
			nxt_w = 1'b0;
			nxt_bv = 1'b1;
			nxt_br = RESP_OK;
			if (awa_ff == OFS_STAT)
			begin
				nxt_stat[STAT_EN] = wd_ff[STAT_EN];
				nxt_stat[STAT_SIDL] = wd_ff[STAT_SIDL];
				// R5: software may only clear overflow
				if (!wd_ff[STAT_ROV])
					nxt_stat[STAT_ROV] = 1'b0;
			end
			else if (awa_ff == OFS_CFG1)
				nxt_cfg1 = wd_ff & CFG1_WMASK;
			else if (awa_ff == OFS_CFG2)
				nxt_cfg2 = wd_ff & CFG2_WMASK;
			else if (awa_ff == OFS_BUF)
			begin
				// R6: buffer write fills transmit buffer
				nxt_txb = wd_ff;
				nxt_stat[STAT_TBF] = 1'b1;
			end
			else
				nxt_br = RESP_SLVERR;
		end
		if (s_axi_arvalid && s_axi_arready)
		begin
			nxt_rv = 1'b1;
			nxt_rr = RESP_OK;
			if (s_axi_araddr == OFS_STAT)
				nxt_rd = {16'h0, stat_ff};
			else if (s_axi_araddr == OFS_CFG1)
				nxt_rd = {16'h0, cfg1_ff};
			else if (s_axi_araddr == OFS_CFG2)
				nxt_rd = {16'h0, cfg2_ff};
			else if (s_axi_araddr == OFS_BUF)
				nxt_rd = {16'h0, rxb_ff};
			else
			begin
				nxt_rd = 32'h0;
				nxt_rr = RESP_SLVERR;
			end
		end
		// R7: buffer read empties receive buffer
		if (rd_buf)
			nxt_stat[STAT_RBF] = 1'b0;
		if (done)
		begin
			// R5: overflow discards; set wins over clear
			if (stat_ff[STAT_RBF] && !rd_buf)
				nxt_stat[STAT_ROV] = 1'b1;
			else
			begin
				// R7: receive buffer filled
				nxt_rxb = wide ? sr_ff : {8'h0, sr_ff[7:0]};
				nxt_stat[STAT_RBF] = 1'b1;
			end
		end
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			aw_ff <= 1'b0;
			w_ff <= 1'b0;
			awa_ff <= 4'h0;
			wd_ff <= RST_REG;
			bv_ff <= 1'b0;
			br_ff <= RESP_OK;
			rv_ff <= 1'b0;
			rd_ff <= 32'h0;
			rr_ff <= RESP_OK;
			stat_ff <= RST_REG;
			cfg1_ff <= RST_REG;
			cfg2_ff <= RST_REG;
			txb_ff <= RST_REG;
			rxb_ff <= RST_REG;
		end
		else
		begin
			aw_ff <= nxt_aw;
			w_ff <= nxt_w;
			awa_ff <= nxt_awa;
			wd_ff <= nxt_wd;
			bv_ff <= nxt_bv;
			br_ff <= nxt_br;
			rv_ff <= nxt_rv;
			rd_ff <= nxt_rd;
			rr_ff <= nxt_rr;
			stat_ff <= nxt_stat;
			cfg1_ff <= nxt_cfg1;
			cfg2_ff <= nxt_cfg2;
			txb_ff <= nxt_txb;
			rxb_ff <= nxt_rxb;
		end
	end

	a_buf_write_full: assert property (@(posedge aclk) disable iff (!aresetn)
		wr_go && awa_ff == OFS_BUF |=> stat_ff[STAT_TBF]) // R6
		else $error("transmit full not set");
	a_load_clears: assert property (@(posedge aclk) disable iff (!aresetn)
		load && !(wr_go && awa_ff == OFS_BUF) |=> !stat_ff[STAT_TBF]) // R6
		else $error("transmit full not cleared");
	a_rx_full_set: assert property (@(posedge aclk) disable iff (!aresetn)
		done && !stat_ff[STAT_RBF] |=> stat_ff[STAT_RBF]) // R7
		else $error("receive full not set");
	a_rx_read_clr: assert property (@(posedge aclk) disable iff (!aresetn)
		rd_buf && !done |=> !stat_ff[STAT_RBF]) // R7
		else $error("receive full not cleared");
	a_overflow_set: assert property (@(posedge aclk) disable iff (!aresetn)
		done && stat_ff[STAT_RBF] && !rd_buf
		|=> stat_ff[STAT_ROV] && $stable(rxb_ff)) // R5
		else $error("overflow not flagged");
	a_sck_disable: assert property (@(posedge aclk) disable iff (!aresetn)
		cfg1_ff[C1_CLOCK_PIN_DISABLE] || !en |-> !shift_clock_pin_oe) // R8
		else $error("clock pin driven while disabled");
	a_sdo_release: assert property (@(posedge aclk) disable iff (!aresetn)
		cfg1_ff[C1_DATA_OUT_DISABLE] |-> !serial_out_pin_oe) // R9
		else $error("data pin driven while released");
	a_idle_halt: assert property (@(posedge aclk) disable iff (!aresetn)
		stat_ff[STAT_SIDL] && idle_mode |-> !tick) // R4
		else $error("clock ran in idle");
	a_word_count: assert property (@(posedge aclk) disable iff (!aresetn)
		st_ff == ST_SHIFT |-> cnt_ff < nbits) // R10
		else $error("bit count beyond width");
	c_buf_write: cover property (@(posedge aclk) wr_go && awa_ff == OFS_BUF);
	c_done: cover property (@(posedge aclk) done);
	c_overflow: cover property (@(posedge aclk) $rose(stat_ff[STAT_ROV]));
	c_framed: cover property (@(posedge aclk) frm && st_ff == ST_SYNC);
endmodule
`default_nettype wire
